/* File: verilog/mmd_consts.svh */
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// ****************************************************************
// Register location and layout
// ****************************************************************
`define MMD_MODE_ADDR 32'h2008_0190
`define MMD_MODE_RESET 32'h0000_0000
`define MMD_BIT_FDM 15
`define MMD_BIT_SECOND_PASS 14
`define MMD_BIT_CACHE_SLOW 13
`define MMD_BIT_TIMER_SEL 12
`define MMD_BIT_SOFT_LOG 11
`define MMD_FLD_PRESCALE_HI 10
`define MMD_FLD_PRESCALE_LO 9
`define MMD_BIT_REFRESH_REQ 8
`define MMD_BIT_DETECT_DIS 7
`define MMD_BIT_PAGE_DIS 6
`define MMD_BIT_FLUSH 5
`define MMD_BIT_FORCE_HIT 4
`define MMD_BIT_FORCE_PAR 3
`define MMD_RW_MASK 32'h0000_FEF8

// ****************************************************************
// Timing
// ****************************************************************
`define MMD_CLK_PERIOD_PS 8000
`define MMD_TO_11_NS 1500
`define MMD_TO_10_NS 12000
`define MMD_TO_01_NS 32000
`define MMD_TO_00_NS 910000
`define MMD_TO_CNT_W 17

`endif

/* File: verilog/mmd_pkg.sv */
// ****************************************************************
// Shared types
// ****************************************************************
package mmd_pkg;
  // Register access sequencer states
  typedef enum logic [1:0] {
    MMD_IDLE,
    MMD_EXTRA,
    MMD_FLUSH,
    MMD_DONE
  } mmd_state_type;

  // Slow-register timeout prescaler codes
  typedef enum logic [1:0] {
    MMD_TO_910US,
    MMD_TO_32US,
    MMD_TO_12US,
    MMD_TO_1US5
  } mmd_prescale_type;
endpackage

/* File: verilog/mmd_err_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// Mode bits passed from the register to the error gate
// ****************************************************************
interface mmd_err_if;
  logic soft_log_en; // Report and log correctable errors
  logic detect_dis; // ECC error detection and reporting off
  logic force_par; // Invert parity checker results
  modport ctrl (output soft_log_en, output detect_dis, output force_par);
  modport gate (input soft_log_en, input detect_dis, input force_par);
endinterface

/* File: verilog/mmd_err_gate.sv */
`timescale 1ns/1ps
// ****************************************************************
// Error reporting gate
// ****************************************************************
module mmd_err_gate
  import mmd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  mmd_err_if.gate mode,
  input wire logic ecc_single_err,
  input wire logic ecc_double_rd,
  input wire logic ecc_double_wr,
  input wire logic proc_par_raw,
  input wire logic periph_par_raw,
  input wire logic proc_io_txn,
  output logic soft_error_irq_n,
  output logic hard_error_irq_n,
  output logic error_reply_n,
  output logic periph_error_n,
  output logic err_log_load,
  output logic soft_status_set,
  output logic lost_status_set
);
  // Detection live only when not disabled
  wire det_on = !mode.detect_dis;
  // Correctable error reported when logging enabled
  wire soft_rep = det_on && ecc_single_err && mode.soft_log_en;
  // Correctable error lost when logging disabled
  wire soft_lost = det_on && ecc_single_err && !mode.soft_log_en;
  // Processor parity ignored on I/O, forced inversion otherwise
  wire proc_par = !proc_io_txn && (proc_par_raw ^ mode.force_par);
  // Peripheral parity with forced inversion
  wire periph_par = periph_par_raw ^ mode.force_par;
  // Hard error report gated by detect disable
  wire hard_rd = det_on && ecc_double_rd;
  wire hard_wr = det_on && ecc_double_wr;

  // ****************************************************************
  // Registered reports
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      soft_error_irq_n <= 1'b1;
      hard_error_irq_n <= 1'b1;
      error_reply_n <= 1'b1;
      periph_error_n <= 1'b1;
      err_log_load <= 1'b0;
      soft_status_set <= 1'b0;
      lost_status_set <= 1'b0;
    end else if (ce) begin
      soft_error_irq_n <= !soft_rep;
      hard_error_irq_n <= !hard_wr;
      error_reply_n <= !(hard_rd || proc_par);
      periph_error_n <= !periph_par;
      err_log_load <= soft_rep || hard_rd || hard_wr;
      soft_status_set <= soft_rep;
      lost_status_set <= soft_lost;
    end
  end
endmodule

/* File: verilog/mmd_mode_ctrl.sv */
`timescale 1ns/1ps
`include "mmd_consts.svh"

// Contract
// - Bit 15 drives mode-select bit 1
// - Bit 14 second pass, only with 15
// - Bit 13 adds one response cycle
// - Bit 12 raises processor-side timer counts
// - Soft logging off: correct, flag lost
// - Soft logging on: interrupt, log, status
// - Bits 10:9 select slow-register timeout
// - Bit 8 set on refresh, read clears
// - Bit 7 disables ECC detection and reporting, not parity
// - Bit 6 ends page mode, drops row-active
// - Writing bit 5 flushes queues, stalls ready
// - Later accesses stall until the flush ends
// - Bit 4 forces write-queue hit
// - Bit 3 inverts both parity checkers
// - Processor I/O ignores bus parity
// - Reset clears writable bits asynchronously
module mmd_mode_ctrl
  import mmd_pkg::*;
#(
  parameter int TO_00_CYC = (`MMD_TO_00_NS * 1000) / `MMD_CLK_PERIOD_PS
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_ready,
  output logic mode_select_out_bit1,
  output logic second_pass,
  output logic cache_two_cycle,
  output logic timer_scale,
  input wire logic refresh_selected,
  output logic page_mode_dis,
  input wire logic mem_txn_end,
  output logic row_active_release,
  output logic flush_request,
  input wire logic queues_empty,
  output logic force_wq_hit,
  input wire logic slow_txn_start,
  input wire logic slow_txn_end,
  output logic slow_txn_timeout,
  input wire logic ecc_single_err,
  input wire logic ecc_double_rd,
  input wire logic ecc_double_wr,
  input wire logic proc_par_raw,
  input wire logic periph_par_raw,
  input wire logic proc_io_txn,
  output logic soft_error_irq_n,
  output logic hard_error_irq_n,
  output logic error_reply_n,
  output logic periph_error_n,
  output logic err_log_load,
  output logic soft_status_set,
  output logic lost_status_set
);
  // ****************************************************************
  // Timeout counts
  // ****************************************************************
  localparam int TO_11_CYC = (`MMD_TO_11_NS * 1000) / `MMD_CLK_PERIOD_PS;
  localparam int TO_10_CYC = (`MMD_TO_10_NS * 1000) / `MMD_CLK_PERIOD_PS;
  localparam int TO_01_CYC = (`MMD_TO_01_NS * 1000) / `MMD_CLK_PERIOD_PS;
  localparam logic [`MMD_TO_CNT_W-1:0] LIM_11 = TO_11_CYC[`MMD_TO_CNT_W-1:0];
  localparam logic [`MMD_TO_CNT_W-1:0] LIM_10 = TO_10_CYC[`MMD_TO_CNT_W-1:0];
  localparam logic [`MMD_TO_CNT_W-1:0] LIM_01 = TO_01_CYC[`MMD_TO_CNT_W-1:0];
  localparam logic [`MMD_TO_CNT_W-1:0] LIM_00 = TO_00_CYC[`MMD_TO_CNT_W-1:0];

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] mode_r; // Register contents
  logic [31:0] mode_nxt; // Next register contents
  mmd_state_type state_r; // Access sequencer
  mmd_state_type state_nxt; // Next sequencer state
  logic flush_r; // Flush in progress
  logic [31:0] rdata_r; // Captured read value
  logic [`MMD_TO_CNT_W-1:0] to_cnt_r; // Slow-register timeout counter
  logic to_run_r; // Timeout counter running
  logic timeout_r; // Timeout pulse
  logic row_rel_r; // Row-active release pulse
  mmd_err_if err_mode (); // Mode bits for the error gate

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire hit = bus_addr == `MMD_MODE_ADDR; // Address match
  wire take = (state_r == MMD_IDLE) && hit && (bus_rd || bus_wr); // Request accepted
  wire take_wr = take && bus_wr; // Accepted write
  wire take_rd = take && !bus_wr; // Accepted read
  wire flush_wr = take_wr && bus_wdata[`MMD_BIT_FLUSH]; // Write asking for a flush
  wire slow_cache = mode_r[`MMD_BIT_CACHE_SLOW]; // Two-cycle cache RAM
  wire [1:0] pre_code = mode_r[`MMD_FLD_PRESCALE_HI:`MMD_FLD_PRESCALE_LO]; // Prescaler code
  wire [`MMD_TO_CNT_W-1:0] lim_sel =
    (pre_code == MMD_TO_1US5) ? LIM_11 :
    (pre_code == MMD_TO_12US) ? LIM_10 :
    (pre_code == MMD_TO_32US) ? LIM_01 : LIM_00;
  // Full count when timer select set, half count otherwise
  wire [`MMD_TO_CNT_W-1:0] to_lim =
    mode_r[`MMD_BIT_TIMER_SEL] ? lim_sel : (lim_sel >> 1);

  // ****************************************************************
  // Register next value
  // ****************************************************************
  always_comb begin
    mode_nxt = mode_r;
    // Software write updates only writable bits
    if (take_wr) begin
      mode_nxt = (mode_r & ~`MMD_RW_MASK) | (bus_wdata & `MMD_RW_MASK);
    end
    // Read clears refresh flag
    if (take_rd) begin
      mode_nxt[`MMD_BIT_REFRESH_REQ] = 1'b0;
    end
    // A new refresh wins over the clear
    if (refresh_selected) begin
      mode_nxt[`MMD_BIT_REFRESH_REQ] = 1'b1;
    end
  end

  // ****************************************************************
  // Access sequencer next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Wait for a request
      MMD_IDLE: begin
        if (take) begin
          if (slow_cache) begin
            state_nxt = MMD_EXTRA;
          end else if (flush_wr) begin
            state_nxt = MMD_FLUSH;
          end else begin
            state_nxt = MMD_DONE;
          end
        end
      end
      // One extra response cycle for slow cache RAM
      MMD_EXTRA: begin
        state_nxt = flush_r ? MMD_FLUSH : MMD_DONE;
      end
      // Hold ready back until the queues drain
      MMD_FLUSH: begin
        if (queues_empty) begin
          state_nxt = MMD_DONE;
        end
      end
      // Ready cycle
      MMD_DONE: begin
        state_nxt = MMD_IDLE;
      end
      default: begin
        state_nxt = MMD_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Register and sequencer flops
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= `MMD_MODE_RESET;
      state_r <= MMD_IDLE;
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      mode_r <= mode_nxt;
      state_r <= state_nxt;
      if (take_rd) begin
        rdata_r <= mode_r;
      end
    end
  end

  // ****************************************************************
  // Flush tracking
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flush_r <= 1'b0;
    end else if (ce) begin
      // Start on a flush write, end when queues are empty
      if (flush_wr) begin
        flush_r <= 1'b1;
      end else if (queues_empty) begin
        flush_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Slow-register timeout counter
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      to_cnt_r <= '0;
      to_run_r <= 1'b0;
      timeout_r <= 1'b0;
    end else if (ce) begin
      timeout_r <= 1'b0;
      if (slow_txn_end) begin
        // Answered: stop and clear
        to_run_r <= 1'b0;
        to_cnt_r <= '0;
      end else if (slow_txn_start) begin
        // Address strobe: start from zero
        to_run_r <= 1'b1;
        to_cnt_r <= '0;
      end else if (to_run_r) begin
        if (to_cnt_r == to_lim - 1'b1) begin
          // Limit reached: abort the transaction
          timeout_r <= 1'b1;
          to_run_r <= 1'b0;
        end else begin
          to_cnt_r <= to_cnt_r + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Row-active release pulse
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      row_rel_r <= 1'b0;
    end else if (ce) begin
      row_rel_r <= mem_txn_end && mode_r[`MMD_BIT_PAGE_DIS];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus_ready = state_r == MMD_DONE;
  assign bus_rdata = rdata_r;
  assign mode_select_out_bit1 = mode_r[`MMD_BIT_FDM];
  assign second_pass = mode_r[`MMD_BIT_FDM] && mode_r[`MMD_BIT_SECOND_PASS];
  assign cache_two_cycle = slow_cache;
  assign timer_scale = mode_r[`MMD_BIT_TIMER_SEL];
  assign page_mode_dis = mode_r[`MMD_BIT_PAGE_DIS];
  assign row_active_release = row_rel_r;
  assign flush_request = flush_r;
  assign force_wq_hit = mode_r[`MMD_BIT_FORCE_HIT];
  assign slow_txn_timeout = timeout_r;
  assign err_mode.soft_log_en = mode_r[`MMD_BIT_SOFT_LOG];
  assign err_mode.detect_dis = mode_r[`MMD_BIT_DETECT_DIS];
  assign err_mode.force_par = mode_r[`MMD_BIT_FORCE_PAR];

  // ****************************************************************
  // Error gate
  // ****************************************************************
  mmd_err_gate i_mmd_err_gate (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .mode(err_mode),
    .ecc_single_err(ecc_single_err),
    .ecc_double_rd(ecc_double_rd),
    .ecc_double_wr(ecc_double_wr),
    .proc_par_raw(proc_par_raw),
    .periph_par_raw(periph_par_raw),
    .proc_io_txn(proc_io_txn),
    .soft_error_irq_n(soft_error_irq_n),
    .hard_error_irq_n(hard_error_irq_n),
    .error_reply_n(error_reply_n),
    .periph_error_n(periph_error_n),
    .err_log_load(err_log_load),
    .soft_status_set(soft_status_set),
    .lost_status_set(lost_status_set)
  );
endmodule

/* File: tb/mmd_queue_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Far-side write queues: drain a fixed time after a flush starts
// ****************************************************************
module mmd_queue_model #(
  parameter int DRAIN = 4
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic flush_request,
  output logic queues_empty
);
  int cnt_r; // Cycles spent flushing so far
  // Count flush cycles, restart when no flush is running
  always_ff @(posedge clock) begin
    if (rst || !flush_request) cnt_r <= 0;
    else if (cnt_r < DRAIN) cnt_r <= cnt_r + 1;
  end
  // Never reports empty early, so the stall is really exercised
  assign queues_empty = !flush_request || (cnt_r == DRAIN);
endmodule

/* File: tb/mmd_mode_ctrl_monitor.sv */
`timescale 1ns/1ps
`include "mmd_consts.svh"
// ****************************************************************
// Port checker for the mode register block
// ****************************************************************
module mmd_mode_ctrl_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_ready,
  input wire logic mode_select_out_bit1,
  input wire logic second_pass,
  input wire logic mem_txn_end,
  input wire logic page_mode_dis,
  input wire logic row_active_release,
  input wire logic flush_request,
  input wire logic queues_empty,
  input wire logic slow_txn_timeout,
  input wire logic soft_error_irq_n,
  input wire logic soft_status_set,
  input wire logic lost_status_set
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Write request aimed at the register
  wire wr_hit = ce && bus_wr && (bus_addr == `MMD_MODE_ADDR);
  property p_fdm;
    wr_hit && $rose(bus_wr) && !bus_wdata[5] |=> mode_select_out_bit1 == $past(bus_wdata[15]);
  endproperty
  a_fdm: assert property (p_fdm) else $error("fast mode output wrong");
  property p_second_pass;
    second_pass |-> mode_select_out_bit1;
  endproperty
  a_second_pass: assert property (p_second_pass) else $error("second pass alone");
  property p_ready_pulse;
    bus_ready |=> !bus_ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_plain_wr;
    wr_hit && !bus_wdata[5] && !flush_request |-> ##[0:2] bus_ready;
  endproperty
  a_plain_wr: assert property (p_plain_wr) else $error("plain write stalled");
  property p_flush_wait;
    ce && flush_request && !queues_empty |=> !bus_ready && flush_request;
  endproperty
  a_flush_wait: assert property (p_flush_wait) else $error("ready before flush end");
  property p_flush_end;
    ce && flush_request && queues_empty |=> bus_ready && !flush_request;
  endproperty
  a_flush_end: assert property (p_flush_end) else $error("flush end missed");
  property p_row;
    ce && mem_txn_end && page_mode_dis && !bus_wr |=> row_active_release;
  endproperty
  a_row: assert property (p_row) else $error("row release missing");
  property p_soft;
    $fell(soft_error_irq_n) |-> soft_status_set;
  endproperty
  a_soft: assert property (p_soft) else $error("soft irq without status");
  property p_excl;
    soft_status_set |-> !lost_status_set;
  endproperty
  a_excl: assert property (p_excl) else $error("soft and lost together");
  property p_to_pulse;
    slow_txn_timeout |=> !slow_txn_timeout;
  endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("timeout pulse too long");
  c_flush: cover property (flush_request && queues_empty);
  c_row: cover property (row_active_release);
  c_timeout: cover property (slow_txn_timeout);
endmodule

bind mmd_mode_ctrl mmd_mode_ctrl_monitor i_mmd_mode_ctrl_monitor (.clock(clock), .rst(rst),
  .ce(ce), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_ready(bus_ready),
  .mode_select_out_bit1(mode_select_out_bit1), .second_pass(second_pass),
  .mem_txn_end(mem_txn_end), .page_mode_dis(page_mode_dis),
  .row_active_release(row_active_release), .flush_request(flush_request),
  .queues_empty(queues_empty), .slow_txn_timeout(slow_txn_timeout),
  .soft_error_irq_n(soft_error_irq_n), .soft_status_set(soft_status_set),
  .lost_status_set(lost_status_set));

/* File: tb/test_memory_ctrl_mode_diag_bits.sv */
`timescale 1ns/1ps
`include "mmd_consts.svh"
module test_memory_ctrl_mode_diag_bits;
  localparam logic [31:0] A = `MMD_MODE_ADDR; // Register address
  logic clock = 1'h0, rst = 1'h1, bus_rd = 1'h0, bus_wr = 1'h0;
  logic [31:0] bus_addr = A, bus_wdata = 32'h0, bus_rdata;
  logic refresh_selected = 1'h0, mem_txn_end = 1'h0, slow_txn_start = 1'h0, slow_txn_end = 1'h0;
  logic [5:0] ev_in = 6'h00; // Error causes
  logic ce = 1'h1; // Clock enable
  logic bus_ready, mode_select_out_bit1, second_pass, cache_two_cycle, timer_scale;
  logic page_mode_dis, row_active_release, flush_request, queues_empty, force_wq_hit;
  logic slow_txn_timeout, soft_error_irq_n, hard_error_irq_n, error_reply_n, periph_error_n;
  logic err_log_load, soft_status_set, lost_status_set;
  int error_cnt = 0, checks_done = 0, n;
  logic [31:0] td[5] = '{32'h1600, 32'h1400, 32'h1200, 32'h1000, 32'h0600}; // Timeout modes
  int tl[5] = '{187, 1500, 4000, 40, 93}; // Expected timeout cycles
  // Clock generator
  always #4 clock = ~clock;
  mmd_mode_ctrl #(.TO_00_CYC(40)) i_mmd_mode_ctrl (.clock(clock), .rst(rst), .ce(ce),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ready(bus_ready), .mode_select_out_bit1(mode_select_out_bit1),
    .second_pass(second_pass), .cache_two_cycle(cache_two_cycle), .timer_scale(timer_scale),
    .refresh_selected(refresh_selected), .page_mode_dis(page_mode_dis),
    .mem_txn_end(mem_txn_end), .row_active_release(row_active_release),
    .flush_request(flush_request), .queues_empty(queues_empty), .force_wq_hit(force_wq_hit),
    .slow_txn_start(slow_txn_start), .slow_txn_end(slow_txn_end),
    .slow_txn_timeout(slow_txn_timeout), .ecc_single_err(ev_in[5]), .ecc_double_rd(ev_in[4]),
    .ecc_double_wr(ev_in[3]), .proc_par_raw(ev_in[2]), .periph_par_raw(ev_in[1]),
    .proc_io_txn(ev_in[0]), .soft_error_irq_n(soft_error_irq_n),
    .hard_error_irq_n(hard_error_irq_n), .error_reply_n(error_reply_n),
    .periph_error_n(periph_error_n), .err_log_load(err_log_load),
    .soft_status_set(soft_status_set), .lost_status_set(lost_status_set));
  mmd_queue_model #(.DRAIN(4)) i_mmd_queue_model (.clock(clock), .rst(rst),
    .flush_request(flush_request), .queues_empty(queues_empty));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access; n gives cycles until ready, capped at lim
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input int lim);
    @(posedge clock);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = w;
    bus_rd = !w;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!bus_ready && n < lim);
    // Hold the request through the edge that samples ready
    if (bus_ready) begin
      @(posedge clock);
      #1;
    end
    bus_wr = 1'h0;
    bus_rd = 1'h0;
  endtask
  task automatic wr(input logic [31:0] d, input int c);
    acc(1'h1, A, d, 20);
    chk(n, c);
    // No answer within the bound: give up and report
    if (n == 20) begin
      complete_run();
    end
  endtask
  task automatic rd(input logic [31:0] exp, input int c);
    acc(1'h0, A, 32'h0, 20);
    chk(n, c);
    chk(bus_rdata, exp);
    // No answer within the bound: give up and report
    if (n == 20) begin
      complete_run();
    end
  endtask
  // One-cycle error cause, outputs checked a cycle later
  task automatic ev(input logic [5:0] c, input logic [5:0] exp);
    ev_in = c;
    @(posedge clock);
    #1;
    ev_in = 6'h00;
    chk({soft_error_irq_n, hard_error_irq_n, error_reply_n, periph_error_n, soft_status_set,
      lost_status_set}, exp);
  endtask
  // Timeout measurement from one slow access start
  task automatic slow(input int lim);
    slow_txn_start = 1'h1;
    @(posedge clock);
    #1;
    slow_txn_start = 1'h0;
    n = 0;
    while (!slow_txn_timeout && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst = 1'h0;
    rd(32'h0, 1);
    wr(32'hFFFF_FFDF, 1);
    rd(`MMD_RW_MASK & 32'hFFFF_FFDF, 2);
    chk({mode_select_out_bit1, second_pass, cache_two_cycle, timer_scale, page_mode_dis,
      force_wq_hit}, 6'h3F);
    mem_txn_end = 1'h1;
    @(posedge clock);
    #1;
    mem_txn_end = 1'h0;
    chk(row_active_release, 1'h1);
    wr(32'h4000, 2);
    chk({mode_select_out_bit1, second_pass}, 2'h0);
    // Write to another address is not taken and changes nothing
    acc(1'h1, A + 32'h4, 32'hFFFF_FFFF, 5);
    chk(n, 5);
    rd(32'h4000, 1);
    $display("test access done");
    wr(32'h8000, 1);
    rst = 1'h1;
    #1 chk(mode_select_out_bit1, 1'h0);
    @(posedge clock);
    #1;
    rst = 1'h0;
    refresh_selected = 1'h1;
    @(posedge clock);
    #1;
    refresh_selected = 1'h0;
    rd(32'h100, 1);
    rd(32'h0, 1);
    wr(32'h20, 6);
    wr(32'h20, 6);
    wr(32'h0, 1);
    // Clock enable low: a refresh pulse is not latched
    ce = 1'h0;
    refresh_selected = 1'h1;
    @(posedge clock);
    #1;
    refresh_selected = 1'h0;
    ce = 1'h1;
    rd(32'h0, 1);
    $display("test reset refresh flush done");
    wr(32'h800, 1);
    ev(6'h20, 6'h1E);
    chk(err_log_load, 1'h1);
    ev(6'h10, 6'h34);
    ev(6'h08, 6'h2C);
    wr(32'h0, 1);
    ev(6'h20, 6'h3D);
    chk(err_log_load, 1'h0);
    ev(6'h04, 6'h34);
    wr(32'h880, 1);
    ev(6'h20, 6'h3C);
    ev(6'h10, 6'h3C);
    ev(6'h08, 6'h3C);
    wr(32'h8, 1);
    ev(6'h00, 6'h30);
    ev(6'h01, 6'h38);
    ev(6'h06, 6'h3C);
    wr(32'h0, 1);
    $display("test errors done");
    foreach (tl[i]) begin
      wr(td[i], 1);
      slow(5000);
      chk(n, tl[i]);
      // Timeout never came: give up and report
      if (n == 5000) begin
        complete_run();
      end
    end
    wr(32'h1000, 1);
    slow(5);
    slow_txn_end = 1'h1;
    @(posedge clock);
    #1;
    slow_txn_end = 1'h0;
    // Answered access: the stopped counter must stay quiet
    n = 0;
    while (!slow_txn_timeout && n < 60) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(n, 60);
    $display("test timeout done");
    complete_run();
  end
endmodule
